// File: src/uav_pkg.sv
package uav_pkg;

    // ==============================
    // register map (byte addresses, one 32-bit word each)
    // ==============================
    localparam logic [4:0]  UAV_ADDR_SETUP     = 5'h00;
    localparam logic [4:0]  UAV_ADDR_USB_STAT  = 5'h04;
    localparam logic [4:0]  UAV_ADDR_USB_MASK  = 5'h08;
    localparam logic [4:0]  UAV_ADDR_FIFO_STAT = 5'h0C;
    localparam logic [4:0]  UAV_ADDR_FIFO_MASK = 5'h10;
    localparam logic [4:0]  UAV_ADDR_VECTORS   = 5'h14;

    // ==============================
    // interrupt_setup_register fields and reset values
    // ==============================
    localparam int          UAV_SETUP_USB_AV_BIT  = 0;
    localparam int          UAV_SETUP_FIFO_AV_BIT = 1;
    localparam int          UAV_SETUP_LIMIT_LSB   = 8;
    localparam int          UAV_LIMIT_W           = 4;
    localparam logic [31:0] UAV_SETUP_RST         = 32'h0000_0000;
    localparam logic [31:0] UAV_MASK_RST          = 32'h0000_0000;
    localparam logic [31:0] UAV_SETUP_WMASK       = 32'h0000_0F03;

    // ==============================
    // source counts, slot layout and vector coding
    // ==============================
    localparam int          UAV_USB_SLOTS   = 32;
    localparam int          UAV_FIFO_SRCS   = 14;
    // slots 14,1C,44,68,6C have no source: 27 live slots remain
    localparam logic [31:0] UAV_USB_LIVE    = 32'hF3FD_FF5F;
    localparam logic [13:0] UAV_FIFO_LIVE   = 14'h3FFF;
    localparam int          UAV_SLOT_IN_NAK = 16;
    localparam int          UAV_SLOT_ERRLIM = 24;
    localparam logic [7:0]  UAV_USB_VEC_BASE  = 8'h00;
    localparam logic [7:0]  UAV_FIFO_VEC_BASE = 8'h80;

    // ==============================
    // jump-table fetch addresses
    // ==============================
    localparam logic [15:0] UAV_USB_JUMP_ADDR  = 16'h0043;
    localparam logic [15:0] UAV_USB_PAGE_ADDR  = 16'h0044;
    localparam logic [15:0] UAV_USB_VEC_ADDR   = 16'h0045;
    localparam logic [15:0] UAV_FIFO_JUMP_ADDR = 16'h0053;
    localparam logic [15:0] UAV_FIFO_PAGE_ADDR = 16'h0054;
    localparam logic [15:0] UAV_FIFO_VEC_ADDR  = 16'h0055;

    // ==============================
    // bus slave states
    // ==============================
    typedef enum logic [1:0] {
        UAV_BUS_IDLE = 2'b01,
        UAV_BUS_ACK  = 2'b10
    } uav_bus_state_t;

endpackage

// File: src/uav_prio_enc.sv
`timescale 1ns/1ps

// =============================================================
// fixed-priority encoder: lowest set index wins
// =============================================================
module uav_prio_enc #(
    parameter int W  = 32,
    parameter int IW = 5
) (
    // request vector, bit 0 highest priority
    input  wire logic [W-1:0]  req,
    // winner
    output logic      [IW-1:0] idx,
    output logic               any
);

    // scan downward so the last hit is the lowest index
    always_comb begin
        idx = '0;
        any = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = IW'(i);
                any = 1'b1;
            end
        end
    end

endmodule // uav_prio_enc

// File: src/uav_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - autovector usb (27) and fifo (14) shared interrupts
// - usb interrupt jumps to 0x0043 handler
// - usb enable substitutes vector at 0x0045
// - fixed priorities, highest pending source wins
// - usb codes 00,04,08,0C,10 for setup/bus
// - codes 18..2C for control and ep0/ep1
// - buffer events ep2..ep8 give 30..3C
// - in bulk nak raises code 40
// - ping nak codes 48..5C
// - error limit exceeded raises code 60
// - iso pid errors give 70..7C
// - fifo codes 80..8C, 90..9C, A0..AC, B0, B4
// - fifo enable substitutes vector at 0x0055
module uav_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // event pulses from the usb engine, one per vector slot
    input  wire logic [31:0] usb_events,
    input  wire logic [4:0]  in_nak_ep,
    input  wire logic        bus_error,
    // event pulses from fifos and waveform engine
    input  wire logic [13:0] fifo_events,
    // core instruction fetch
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    input  wire logic [7:0]  fetch_mem_data,
    output logic      [7:0]  fetch_data,
    output logic             fetch_valid,
    // interrupt lines to the core
    output logic             usb_shared_interrupt,
    output logic             fifo_shared_interrupt,
    output logic             irq
);
    import uav_pkg::*;

    // ==============================
    // state
    // ==============================
    logic [31:0]                setup_reg;
    logic [31:0]                usb_stat_reg;
    logic [31:0]                usb_mask_reg;
    logic [13:0]                fifo_stat_reg;
    logic [13:0]                fifo_mask_reg;
    logic [UAV_LIMIT_W-1:0]     err_cnt_reg;
    logic [7:0]                 usb_vector_byte;
    logic [7:0]                 fifo_vector_byte;
    uav_bus_state_t             bus_state_reg;
    logic [31:0]                usb_set;
    logic [13:0]                fifo_set;
    logic [31:0]                usb_pend;
    logic [13:0]                fifo_pend;
    logic [4:0]                 usb_idx;
    logic [3:0]                 fifo_idx;
    logic                       usb_any;
    logic                       fifo_any;
    logic                       wr_go;
    logic [31:0]                wmask;
    logic                       err_hit;
    logic [UAV_LIMIT_W-1:0]     err_limit;
    logic                       usb_av_en;
    logic                       fifo_av_en;

    // w1c update; a new event in the clear cycle survives
    function automatic logic [31:0] w1c(input logic [31:0] cur,
                                        input logic [31:0] clr,
                                        input logic [31:0] set);
        return (cur & ~clr) | set;
    endfunction

    // ==============================
    // avalon slave: one wait cycle, then answer
    // ==============================
    assign avs_waitrequest = (avs_read | avs_write) && (bus_state_reg != UAV_BUS_ACK);
    assign wr_go           = avs_write && (bus_state_reg == UAV_BUS_ACK);
    assign wmask           = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // handshake sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bus_state_reg <= UAV_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                UAV_BUS_IDLE: begin
                    if (avs_read | avs_write) begin
                        bus_state_reg <= UAV_BUS_ACK;
                    end
                end
                UAV_BUS_ACK: begin
                    bus_state_reg <= UAV_BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= UAV_BUS_IDLE;
                end
            endcase
        end
    end

    // read data is loaded in the wait cycle so it stands at the answer edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state_reg == UAV_BUS_IDLE) begin
            case (avs_address)
                UAV_ADDR_SETUP:     avs_readdata <= setup_reg;
                UAV_ADDR_USB_STAT:  avs_readdata <= usb_stat_reg;
                UAV_ADDR_USB_MASK:  avs_readdata <= usb_mask_reg;
                UAV_ADDR_FIFO_STAT: avs_readdata <= {18'h0_0000, fifo_stat_reg};
                UAV_ADDR_FIFO_MASK: avs_readdata <= {18'h0_0000, fifo_mask_reg};
                UAV_ADDR_VECTORS:   avs_readdata <= {14'h0000, fifo_any, usb_any,
                                                     fifo_vector_byte, usb_vector_byte};
                default:            avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==============================
    // setup and mask registers
    // ==============================
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            setup_reg <= UAV_SETUP_RST;
        end else if (wr_go && avs_address == UAV_ADDR_SETUP) begin
            setup_reg <= (setup_reg & ~(wmask & UAV_SETUP_WMASK))
                       | (avs_writedata & wmask & UAV_SETUP_WMASK);
        end
    end

    // masks only cover live sources, so reserved slots can never pend
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            usb_mask_reg  <= UAV_MASK_RST;
            fifo_mask_reg <= UAV_MASK_RST[13:0];
        end else if (wr_go) begin
            if (avs_address == UAV_ADDR_USB_MASK) begin
                usb_mask_reg <= ((usb_mask_reg & ~wmask) | (avs_writedata & wmask))
                              & UAV_USB_LIVE;
            end
            if (avs_address == UAV_ADDR_FIFO_MASK) begin
                fifo_mask_reg <= ((fifo_mask_reg & ~wmask[13:0])
                               | (avs_writedata[13:0] & wmask[13:0])) & UAV_FIFO_LIVE;
            end
        end
    end

    assign usb_av_en  = setup_reg[UAV_SETUP_USB_AV_BIT];
    assign fifo_av_en = setup_reg[UAV_SETUP_FIFO_AV_BIT];
    assign err_limit  = setup_reg[UAV_SETUP_LIMIT_LSB +: UAV_LIMIT_W];

    // ==============================
    // bus error counter
    // ==============================
    // counter restarts after each hit so a burst keeps raising the source
    assign err_hit = bus_error && (err_cnt_reg >= err_limit);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            err_cnt_reg <= '0;
        end else if (err_hit) begin
            err_cnt_reg <= '0;
        end else if (bus_error) begin
            err_cnt_reg <= err_cnt_reg + 1'b1;
        end
    end

    // ==============================
    // sticky status
    // ==============================
    // slot n of usb_events carries the source with vector 4*n
    always_comb begin
        usb_set                  = usb_events & UAV_USB_LIVE;
        usb_set[UAV_SLOT_IN_NAK] = usb_events[UAV_SLOT_IN_NAK] | (|in_nak_ep);
        usb_set[UAV_SLOT_ERRLIM] = usb_events[UAV_SLOT_ERRLIM] | err_hit;
        fifo_set                 = fifo_events & UAV_FIFO_LIVE;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            usb_stat_reg <= 32'h0000_0000;
        end else begin
            usb_stat_reg <= w1c(usb_stat_reg,
                (wr_go && avs_address == UAV_ADDR_USB_STAT) ? avs_writedata & wmask
                                                            : 32'h0000_0000,
                usb_set);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fifo_stat_reg <= 14'h0000;
        end else begin
            fifo_stat_reg <= (fifo_stat_reg & ~(wr_go && avs_address == UAV_ADDR_FIFO_STAT
                             ? avs_writedata[13:0] & wmask[13:0] : 14'h0000)) | fifo_set;
        end
    end

    // ==============================
    // vector selection
    // ==============================
    assign usb_pend  = usb_stat_reg & usb_mask_reg;
    assign fifo_pend = fifo_stat_reg & fifo_mask_reg;

    uav_prio_enc #(.W(UAV_USB_SLOTS), .IW(5)) u_usb_enc (
        .req (usb_pend),
        .idx (usb_idx),
        .any (usb_any)
    );

    uav_prio_enc #(.W(UAV_FIFO_SRCS), .IW(4)) u_fifo_enc (
        .req (fifo_pend),
        .idx (fifo_idx),
        .any (fifo_any)
    );

    // vector is four times the slot index above each base
    assign usb_vector_byte  = UAV_USB_VEC_BASE  | {1'b0, usb_idx, 2'b00};
    assign fifo_vector_byte = UAV_FIFO_VEC_BASE | {2'b00, fifo_idx, 2'b00};

    // level interrupts toward the core
    assign usb_shared_interrupt  = usb_any;
    assign fifo_shared_interrupt = fifo_any;
    assign irq                   = usb_any | fifo_any;

    // ==============================
    // fetch substitution
    // ==============================
    // only the low vector byte is replaced; jump opcode and page come from memory
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fetch_data  <= 8'h00;
            fetch_valid <= 1'b0;
        end else begin
            fetch_valid <= fetch_req;
            if (fetch_req) begin
                if (usb_av_en && fetch_addr == UAV_USB_VEC_ADDR) begin
                    fetch_data <= usb_vector_byte;
                end else if (fifo_av_en && fetch_addr == UAV_FIFO_VEC_ADDR) begin
                    fetch_data <= fifo_vector_byte;
                end else begin
                    fetch_data <= fetch_mem_data;
                end
            end
        end
    end

    // ==============================
    // checks
    // ==============================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_usb_vec_fetch;
        fetch_req && usb_av_en && fetch_addr == UAV_USB_VEC_ADDR;
    endsequence

    sequence s_fifo_vec_fetch;
        fetch_req && fifo_av_en && fetch_addr == UAV_FIFO_VEC_ADDR;
    endsequence

    a_usb_vec_subst: assert property (
        s_usb_vec_fetch |=> fetch_valid && fetch_data == $past(usb_vector_byte))
        else $error("usb vector not substituted");

    a_fifo_vec_subst: assert property (
        s_fifo_vec_fetch |=> fetch_valid && fetch_data == $past(fifo_vector_byte))
        else $error("fifo vector not substituted");

    a_pass_through: assert property (
        fetch_req && !(usb_av_en && fetch_addr == UAV_USB_VEC_ADDR)
            && !(fifo_av_en && fetch_addr == UAV_FIFO_VEC_ADDR)
        |=> fetch_data == $past(fetch_mem_data))
        else $error("fetch byte altered");

    a_page_untouched: assert property (
        fetch_req && (fetch_addr == UAV_USB_PAGE_ADDR || fetch_addr == UAV_FIFO_PAGE_ADDR
            || fetch_addr == UAV_USB_JUMP_ADDR || fetch_addr == UAV_FIFO_JUMP_ADDR)
        |=> fetch_data == $past(fetch_mem_data))
        else $error("page or jump byte altered");

    a_no_reserved: assert property (
        usb_any |-> !(usb_vector_byte inside {8'h14, 8'h1C, 8'h44, 8'h68, 8'h6C}))
        else $error("reserved usb vector presented");

    a_usb_priority: assert property (
        usb_any |-> usb_pend[usb_idx] && ((usb_pend & ((32'h1 << usb_idx) - 1)) == 0))
        else $error("usb vector not highest priority");

    a_fifo_priority: assert property (
        fifo_any |-> fifo_pend[fifo_idx]
            && ((fifo_pend & ((14'h1 << fifo_idx) - 14'h1)) == 0)
            && fifo_vector_byte >= 8'h80 && fifo_vector_byte <= 8'hB4)
        else $error("fifo vector wrong");

    a_nak_sets: assert property (
        (|in_nak_ep) |=> usb_stat_reg[UAV_SLOT_IN_NAK])
        else $error("in bulk nak not recorded");

    a_event_beats_clr: assert property (
        usb_set[0] |=> usb_stat_reg[0])
        else $error("usb event lost");

    a_usb_irq_level: assert property (
        usb_shared_interrupt == ((usb_stat_reg & usb_mask_reg) != 32'h0000_0000))
        else $error("usb interrupt level wrong");

    sequence s_bus_req;
        (avs_read || avs_write) && bus_state_reg == UAV_BUS_IDLE;
    endsequence

    a_bus_answer: assert property (
        s_bus_req |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait");

    a_err_limit: assert property (
        bus_error && err_cnt_reg >= err_limit |=> usb_stat_reg[UAV_SLOT_ERRLIM]
            && err_cnt_reg == '0)
        else $error("error limit source not raised");

endmodule // uav_top

// File: bench/uav_core_model.sv
`timescale 1ns/1ps

// =============================================================
// core model: fetches the jump, page and vector bytes of a table
// =============================================================
module uav_core_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // interrupt taken, one-cycle request
    input  wire logic        take_usb,
    input  wire logic        take_fifo,
    // fetch port toward the block
    output logic             fetch_req,
    output logic      [15:0] fetch_addr,
    output logic      [7:0]  fetch_mem_data,
    input  wire logic [7:0]  fetch_data,
    input  wire logic        fetch_valid,
    // bytes the core ended up with
    output logic      [7:0]  got_page,
    output logic      [7:0]  got_vec,
    output logic             done
);
    import uav_pkg::*;

    logic        busy;
    logic [1:0]  n_iss;
    logic [1:0]  n_got;
    logic [15:0] base;

    // three back-to-back fetches; idle lines toggle so stale values never pass
    always @(posedge mclk) begin
        done <= 1'b0;
        if (sys_rst) begin
            busy           <= 1'b0;
            fetch_req      <= 1'b0;
            fetch_addr     <= 16'h0000;
            fetch_mem_data <= 8'h00;
            n_iss          <= 2'd0;
            n_got          <= 2'd0;
        end else begin
            if (!busy && (take_usb || take_fifo)) begin
                busy  <= 1'b1;
                n_iss <= 2'd0;
                n_got <= 2'd0;
                base  <= take_fifo ? UAV_FIFO_JUMP_ADDR : UAV_USB_JUMP_ADDR;
            end
            if (busy && n_iss != 2'd3) begin
                fetch_req      <= 1'b1;
                fetch_addr     <= base + {14'h0000, n_iss};
                // memory: jump opcode, page (0x12 usb, 0x13 fifo), then 0xE5
                fetch_mem_data <= (n_iss == 2'd0) ? 8'h02 :
                                  (n_iss == 2'd1) ? (base[4] ? 8'h13 : 8'h12) : 8'hE5;
                n_iss          <= n_iss + 2'd1;
            end else begin
                fetch_req      <= 1'b0;
                fetch_addr     <= ~fetch_addr;
                fetch_mem_data <= ~fetch_mem_data;
            end
            // answers come back in order, one per request
            if (fetch_valid) begin
                n_got <= n_got + 2'd1;
                if (n_got == 2'd1) begin
                    got_page <= fetch_data;
                end
                if (n_got == 2'd2) begin
                    got_vec <= fetch_data;
                    busy    <= 1'b0;
                    done    <= 1'b1;
                end
            end
        end
    end
endmodule // uav_core_model

// File: bench/usb_fifo_interrupt_autovector_tb.sv
`timescale 1ns/1ps

module usb_fifo_interrupt_autovector_tb;
    import uav_pkg::*;

    // ==============================
    // design signals and bench model state
    // ==============================
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] usb_events = 32'h0000_0000;
    logic [4:0]  in_nak_ep = 5'h00;
    logic        bus_error = 1'b0;
    logic [13:0] fifo_events = 14'h0000;
    logic        fetch_req, fetch_valid, core_done;
    logic [15:0] fetch_addr;
    logic [7:0]  fetch_mem_data, fetch_data, got_page, got_vec;
    logic        usb_shared_interrupt, fifo_shared_interrupt, irq;
    logic        take_usb = 1'b0;
    logic        take_fifo = 1'b0;
    logic [31:0] m_setup, m_ustat, m_umask, m_fstat, m_fmask, rnd, rd;
    int          m_errs, n_fail, samples_checked;
    logic [7:0]  exp_q[$];

    always #12.5 mclk = ~mclk;

    uav_top DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .usb_events(usb_events), .in_nak_ep(in_nak_ep),
        .bus_error(bus_error), .fifo_events(fifo_events), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_mem_data(fetch_mem_data), .fetch_data(fetch_data),
        .fetch_valid(fetch_valid), .usb_shared_interrupt(usb_shared_interrupt),
        .fifo_shared_interrupt(fifo_shared_interrupt), .irq(irq));

    uav_core_model core (.mclk(mclk), .sys_rst(sys_rst), .take_usb(take_usb),
        .take_fifo(take_fifo), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_mem_data(fetch_mem_data), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
        .got_page(got_page), .got_vec(got_vec), .done(core_done));

    // ==============================
    // reporting
    // ==============================
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ==============================
    // reference model: lowest pending slot wins, 4 per slot
    // ==============================
    function automatic logic [7:0] vec(input logic [31:0] p, input logic [7:0] b);
        for (int i = 0; i < 32; i++) begin
            if (p[i]) return b + 8'(4 * i);
        end
        return b;
    endfunction

    function automatic logic [31:0] reg_exp(input logic [4:0] a);
        logic [31:0] up, fp;
        up = m_ustat & m_umask;
        fp = m_fstat & m_fmask;
        case (a)
            UAV_ADDR_SETUP:     return m_setup;
            UAV_ADDR_USB_STAT:  return m_ustat;
            UAV_ADDR_USB_MASK:  return m_umask;
            UAV_ADDR_FIFO_STAT: return m_fstat;
            UAV_ADDR_FIFO_MASK: return m_fmask;
            UAV_ADDR_VECTORS:   return {14'h0, |fp, |up, vec(fp, UAV_FIFO_VEC_BASE),
                                        vec(up, UAV_USB_VEC_BASE)};
            default:            return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ==============================
    // stimulus tasks
    // ==============================
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        logic [31:0] m;
        int          i;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        @(posedge mclk);
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (wr) begin
            case (a)
                UAV_ADDR_SETUP:     m_setup = ((m_setup & ~m) | (d & m)) & UAV_SETUP_WMASK;
                UAV_ADDR_USB_STAT:  m_ustat = m_ustat & ~(d & m);
                UAV_ADDR_USB_MASK:  m_umask = ((m_umask & ~m) | (d & m)) & UAV_USB_LIVE;
                UAV_ADDR_FIFO_STAT: m_fstat = m_fstat & ~(d & m);
                UAV_ADDR_FIFO_MASK: m_fmask = ((m_fmask & ~m) | (d & m)) & 32'h0000_3FFF;
                default: ;
            endcase
        end
    endtask

    // one-cycle events; the error counter rolls over past the limit
    task automatic pulse(input logic [31:0] u, input logic [13:0] f, input logic [4:0] nak,
                         input logic be);
        @(posedge mclk);
        usb_events  <= u;
        fifo_events <= f;
        in_nak_ep   <= nak;
        bus_error   <= be;
        @(posedge mclk);
        usb_events  <= 32'h0000_0000;
        fifo_events <= 14'h0000;
        in_nak_ep   <= 5'h00;
        bus_error   <= 1'b0;
        m_ustat = m_ustat | (u & UAV_USB_LIVE);
        m_fstat = m_fstat | {18'h0, f};
        if (nak != 5'h00) m_ustat[UAV_SLOT_IN_NAK] = 1'b1;
        if (be && m_errs >= int'(m_setup[11:8])) begin
            m_ustat[UAV_SLOT_ERRLIM] = 1'b1;
            m_errs = 0;
        end else if (be) begin
            m_errs++;
        end
    endtask

    task automatic fetch(input logic fifo);
        logic [31:0] v;
        int          i;
        v = reg_exp(UAV_ADDR_VECTORS);
        exp_q.push_back(fifo ? (m_setup[1] ? v[15:8] : 8'hE5) : (m_setup[0] ? v[7:0] : 8'hE5));
        @(posedge mclk);
        take_usb  <= !fifo;
        take_fifo <= fifo;
        @(posedge mclk);
        take_usb  <= 1'b0;
        take_fifo <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (core_done === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
        check({got_page, got_vec}, {(fifo ? 8'h13 : 8'h12), exp_q.pop_front()}, "fetch");
    endtask

    // every register, the unmapped word, the lines and both fetches
    task automatic check_state();
        logic [31:0] up, fp;
        for (int a = 0; a <= 24; a += 4) begin
            bus(1'b0, 5'(a), 32'h0000_0000, 4'hF);
            check(rd, reg_exp(5'(a)), "register");
        end
        up = m_ustat & m_umask;
        fp = m_fstat & m_fmask;
        @(negedge mclk);
        check({29'h0, usb_shared_interrupt, fifo_shared_interrupt, irq},
              {29'h0, |up, |fp, |(up | fp)}, "interrupt lines");
        fetch(1'b0);
        fetch(1'b1);
    endtask

    task automatic clear();
        bus(1'b1, UAV_ADDR_USB_STAT, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, UAV_ADDR_FIFO_STAT, 32'hFFFF_FFFF, 4'hF);
    endtask

    // ==============================
    // main sequence
    // ==============================
    initial begin
        {m_setup, m_ustat, m_umask, m_fstat, m_fmask} = '0;
        {m_errs, n_fail, samples_checked} = '0;
        rnd = 32'h8b41;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        check_state();
        $display("test reset values done");
        bus(1'b1, UAV_ADDR_SETUP, 32'hFFFF_F2FF, 4'hF); // limit 2, both enables
        bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, UAV_ADDR_USB_MASK, 32'hFFFF_FFFF, 4'h1);
        check_state();
        bus(1'b1, UAV_ADDR_USB_MASK, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, UAV_ADDR_FIFO_MASK, 32'hFFFF_FFFF, 4'hF);
        $display("test setup and lanes done");
        for (int n = 0; n < 32; n++) begin
            pulse(32'h1 << n, 14'h0000, 5'h00, 1'b0);
            check_state();
            clear();
        end
        for (int n = 0; n < 14; n++) begin
            pulse(32'h0000_0000, 14'h1 << n, 5'h00, 1'b0);
            check_state();
            clear();
        end
        $display("test single sources done");
        pulse(32'h0000_0000, 14'h0000, 5'h04, 1'b0);
        check_state();
        clear();
        repeat (3) begin
            pulse(32'h0000_0000, 14'h0000, 5'h00, 1'b1);
            check_state();
        end
        clear();
        $display("test nak and error limit done");
        repeat (6) begin
            rnd = lfsr(rnd);
            bus(1'b1, UAV_ADDR_USB_MASK, rnd, 4'hF);
            rnd = lfsr(rnd);
            bus(1'b1, UAV_ADDR_FIFO_MASK, rnd, 4'hF);
            rnd = lfsr(rnd);
            pulse(rnd, rnd[31:18], rnd[4:0], 1'b0);
            check_state();
            clear();
        end
        $display("test random priority done");
        bus(1'b1, UAV_ADDR_SETUP, 32'h0000_0000, 4'hF);
        bus(1'b1, UAV_ADDR_USB_MASK, 32'hFFFF_FFFF, 4'hF);
        pulse(32'h0000_0300, 14'h0004, 5'h00, 1'b0);
        check_state();
        $display("test autovector off done");
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        {m_setup, m_ustat, m_umask, m_fstat, m_fmask} = '0;
        m_errs = 0;
        check_state();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule // usb_fifo_interrupt_autovector_tb
